/* File: verilog/ela_defs.vh */
`ifndef ELA_DEFS_VH
`define ELA_DEFS_VH

// Trigger condition encodings, three bits per channel
`define COND_IGNORE   3'h0
`define COND_LOW      3'h1
`define COND_HIGH     3'h2
`define COND_RISE     3'h3
`define COND_FALL     3'h4
`define COND_EITHER   3'h5
`define COND_W        3

// Default geometry
`define DEF_CHANNELS  128
`define DEF_DEPTH     128

// Window split in percent
`define PRE_PERCENT   88
`define POST_PERCENT  12

// Capture state codes
`define ST_IDLE       2'h0
`define ST_ARMED      2'h1
`define ST_POST       2'h2
`define ST_DONE       2'h3

`endif

/* File: verilog/sample_ram.v */
`timescale 1ns/10ps
module sample_ram #(
    parameter WIDTH = 128,
    parameter AW    = 7
) (
    input  wire             core_clk_i, // Sampling clock
    input  wire             wr_en_i,    // Write strobe
    input  wire [AW-1:0]    wr_addr_i,  // Write address
    input  wire [WIDTH-1:0] wr_data_i,  // Write data
    input  wire [AW-1:0]    rd_addr_i,  // Read address
    output reg  [WIDTH-1:0] rd_data_o   // Registered read data
);

    reg [WIDTH-1:0] mem [0:(1<<AW)-1];

    always @(posedge core_clk_i) begin
        if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
        rd_data_o <= mem[rd_addr_i];
    end

endmodule // sample_ram

/* File: verilog/ela_trigger.v */
`timescale 1ns/10ps
`include "ela_defs.vh"

//Contract
// - capture window holds 88 percent pre-trigger and 12 percent post-trigger samples.
// - up to 128 probed input channels are supported.
// - sampling, comparison and storage all run on one clock.
// - each channel takes one of six conditions chosen by the host.
// - every channel condition resets to ignore, masking it from triggering.
// - trigger fires when every unmasked channel meets its condition, registered compare; the code also holds it off until PRE samples have been written.
// - sample buffer depth of 128 samples per channel is supported.
module ela_trigger #(
    parameter CHANNELS = `DEF_CHANNELS,
    parameter DEPTH    = `DEF_DEPTH,
    parameter AW       = 7
) (
    input  wire                       core_clk_i,   // Sampling clock
    input  wire                       rst_i,        // Synchronous reset, active high
    input  wire [CHANNELS-1:0]        probe_i,      // Probed design nodes
    input  wire                       cond_we_i,    // Write strobe for one channel condition
    input  wire [7:0]                 cond_ch_i,    // Channel index for the write
    input  wire [`COND_W-1:0]         cond_val_i,   // Condition value for the write
    input  wire                       arm_i,        // Start a capture
    input  wire [AW-1:0]              rd_addr_i,    // Readback index, 0 is oldest sample
    output reg  [CHANNELS-1:0]        rd_data_o,    // Readback sample
    output reg                        armed_o,      // Capture running
    output reg                        triggered_o,  // One-cycle pulse at trigger
    output reg                        done_o,       // Window complete
    output reg  [AW-1:0]              trig_pos_o    // Readback index of trigger sample
);

    // -------------------------------------------------------------------
    // Window geometry
    // -------------------------------------------------------------------
    localparam POST = (DEPTH * `POST_PERCENT) / 100;
    localparam PRE  = DEPTH - POST;

    // Capture states
    localparam [1:0] S_IDLE  = `ST_IDLE;
    localparam [1:0] S_ARMED = `ST_ARMED;
    localparam [1:0] S_POST  = `ST_POST;
    localparam [1:0] S_DONE  = `ST_DONE;

    // -------------------------------------------------------------------
    // Condition table and sampling
    // -------------------------------------------------------------------
    reg [`COND_W*CHANNELS-1:0] cond;
    reg [CHANNELS-1:0]         cur;
    reg [CHANNELS-1:0]         prev;
    reg [CHANNELS-1:0]         hit;
    reg                        match;
    reg [1:0]                  state;
    reg [AW-1:0]               wptr;
    reg [AW-1:0]               trig_ptr;
    reg [AW:0]                 fill;
    reg [AW:0]                 post_cnt;
    reg                        match_seen;
    reg [1:0]                  next_state;
    wire                       fire;
    wire                       post_last;
    wire                       capturing;
    wire [AW-1:0]              ram_rd_addr;
    wire [CHANNELS-1:0]        ram_q;
    integer                    i;

    function chan_hit;
        input [`COND_W-1:0] c;
        input               now;
        input               was;
        begin
            case (c)
                `COND_LOW:    chan_hit = ~now;
                `COND_HIGH:   chan_hit = now;
                `COND_RISE:   chan_hit = now & ~was;
                `COND_FALL:   chan_hit = ~now & was;
                `COND_EITHER: chan_hit = now ^ was;
                default:      chan_hit = 1'b1;
            endcase
        end
    endfunction

    always @(posedge core_clk_i) begin
        if (rst_i) begin
            cond <= {(`COND_W*CHANNELS){1'b0}};
        end else if (cond_we_i && (cond_ch_i < CHANNELS)) begin
            cond[cond_ch_i*`COND_W +: `COND_W] <= cond_val_i;
        end
    end

    always @* begin
        for (i = 0; i < CHANNELS; i = i + 1) begin
            hit[i] = chan_hit(cond[i*`COND_W +: `COND_W], cur[i], prev[i]);
        end
    end

    always @(posedge core_clk_i) begin
        if (rst_i) begin
            cur   <= {CHANNELS{1'b0}};
            prev  <= {CHANNELS{1'b0}};
            match <= 1'b0;
        end else begin
            cur   <= probe_i;
            prev  <= cur;
            match <= &hit;
        end
    end

    // -------------------------------------------------------------------
    // Capture control
    // -------------------------------------------------------------------
    // Trigger waits for a full pre-trigger history in the buffer
    assign fire      = match && match_seen && (fill >= PRE[AW:0]);
    // The trigger write itself is the first of the POST samples
    assign post_last = (post_cnt == POST[AW:0] - 2'd2);
    // Buffer is written on every cycle of a capture
    assign capturing = (state == S_ARMED) || (state == S_POST);

    always @* begin
        next_state = state;
        case (state)
            S_IDLE, S_DONE: begin
                if (arm_i) begin
                    next_state = S_ARMED;
                end
            end
            S_ARMED: begin
                if (fire) begin
                    next_state = S_POST;
                end
            end
            S_POST: begin
                if (post_last) begin
                    next_state = S_DONE;
                end
            end
            default: begin
                next_state = S_IDLE;
            end
        endcase
    end

    always @(posedge core_clk_i) begin
        if (rst_i) begin
            state <= S_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always @(posedge core_clk_i) begin
        if (rst_i) begin
            wptr        <= {AW{1'b0}};
            trig_ptr    <= {AW{1'b0}};
            fill        <= {(AW+1){1'b0}};
            post_cnt    <= {(AW+1){1'b0}};
            match_seen  <= 1'b0;
            armed_o     <= 1'b0;
            triggered_o <= 1'b0;
            done_o      <= 1'b0;
            trig_pos_o  <= {AW{1'b0}};
        end else begin
            triggered_o <= 1'b0;
            match_seen  <= 1'b0;
            if (((state == S_IDLE) || (state == S_DONE)) && arm_i) begin
                wptr     <= {AW{1'b0}};
                fill     <= {(AW+1){1'b0}};
                post_cnt <= {(AW+1){1'b0}};
                armed_o  <= 1'b1;
                done_o   <= 1'b0;
            end
            // Ring buffer keeps the newest PRE samples while waiting
            if (state == S_ARMED) begin
                wptr       <= wptr + 1'b1;
                match_seen <= 1'b1;
                if (fill < PRE[AW:0]) begin
                    fill <= fill + 1'b1;
                end
                if (fire) begin
                    trig_ptr    <= wptr;
                    triggered_o <= 1'b1;
                    post_cnt    <= {(AW+1){1'b0}};
                end
            end
            // Post-trigger writes overwrite only the oldest slots
            if (state == S_POST) begin
                wptr     <= wptr + 1'b1;
                post_cnt <= post_cnt + 1'b1;
                if (post_last) begin
                    armed_o    <= 1'b0;
                    done_o     <= 1'b1;
                    trig_pos_o <= PRE[AW-1:0];
                end
            end
        end
    end

    // Readback is rotated so address 0 is the oldest sample of the window
    assign ram_rd_addr = rd_addr_i + trig_ptr - PRE[AW-1:0];

    always @(posedge core_clk_i) begin
        if (rst_i) begin
            rd_data_o <= {CHANNELS{1'b0}};
        end else begin
            rd_data_o <= ram_q;
        end
    end

    // -------------------------------------------------------------------
    // Sample storage
    // -------------------------------------------------------------------
    sample_ram #(
        .WIDTH (CHANNELS),
        .AW    (AW)
    ) u_ram (
        .core_clk_i (core_clk_i),
        .wr_en_i    (capturing),
        .wr_addr_i  (wptr),
        // prev lines up with the registered match, so the trigger sample lands at trig_ptr
        .wr_data_i  (prev),
        .rd_addr_i  (ram_rd_addr),
        .rd_data_o  (ram_q)
    );

endmodule // ela_trigger

/* File: dv/ela_trigger_properties.sv */
`timescale 1ns/10ps
module ela_trigger_properties #(
    parameter DEPTH = 128,
    parameter AW    = 7
) (
    input wire          core_clk_i,
    input wire          rst_i,
    input wire          arm_i,
    input wire          armed_o,
    input wire          triggered_o,
    input wire          done_o,
    input wire [AW-1:0] trig_pos_o
);
    localparam [AW-1:0] PRE_POS = DEPTH - DEPTH * 12 / 100;
    reg [7:0] fill;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    always @(posedge core_clk_i) begin
        if (rst_i || !armed_o) fill <= 8'h00;
        else if (fill != 8'hFF) fill <= fill + 8'h01;
    end
    AST_RST: assert property (disable iff (1'b0) rst_i |=> !armed_o && !done_o && !triggered_o) else $error("outputs active after reset");
    AST_ARM: assert property (arm_i && !armed_o |=> armed_o) else $error("arm not taken");
    AST_PULSE: assert property (triggered_o |=> !triggered_o) else $error("trigger pulse too long");
    AST_PREFILL: assert property (triggered_o |-> armed_o && fill > {1'b0, PRE_POS}) else $error("trigger before pre fill");
    AST_POSTRUN: assert property (triggered_o |-> armed_o [*8]) else $error("capture stopped early");
    AST_DONE: assert property (triggered_o |-> ##14 done_o) else $error("done not after post count");
    AST_POS: assert property (done_o |-> trig_pos_o == PRE_POS) else $error("trigger position wrong");
    AST_HOLD: assert property (done_o && !arm_i |=> done_o && !armed_o) else $error("done not held");
endmodule // ela_trigger_properties
bind ela_trigger ela_trigger_properties #(.DEPTH(DEPTH), .AW(AW)) i_props (.core_clk_i(core_clk_i), .rst_i(rst_i),
    .arm_i(arm_i), .armed_o(armed_o), .triggered_o(triggered_o), .done_o(done_o), .trig_pos_o(trig_pos_o));

/* File: dv/host_model.sv */
`timescale 1ns/10ps
module host_model (
    input  wire       core_clk_i, // Sampling clock
    output reg        we_o,       // Condition write strobe
    output reg  [7:0] ch_o,       // Channel index
    output reg  [2:0] val_o,      // Condition value
    output reg        arm_o       // Capture start
);
    initial begin
        we_o = 1'b0; ch_o = 8'h00; val_o = 3'h0; arm_o = 1'b0;
    end
    task set_cond(input [7:0] ch, input [2:0] val);
        begin
            @(posedge core_clk_i); we_o <= 1'b1; ch_o <= ch; val_o <= val;
            @(posedge core_clk_i); we_o <= 1'b0; ch_o <= ~ch; val_o <= ~val;
        end
    endtask
    task arm;
        begin
            @(posedge core_clk_i); arm_o <= 1'b1;
            @(posedge core_clk_i); arm_o <= 1'b0;
        end
    endtask
endmodule // host_model

/* File: dv/ela_trigger_tb.sv */
`timescale 1ns/10ps
`include "ela_defs.vh"
module ela_trigger_tb;
    reg          core_clk_i, rst_i, lead, hit;
    reg  [127:0] probe_i, prev;
    reg  [6:0]   rd_addr_i;
    wire         we, arm, armed_o, triggered_o, done_o;
    wire [7:0]   ch;
    wire [2:0]   val;
    wire [127:0] rd_data_o;
    wire [6:0]   trig_pos_o;
    integer      mismatches = 0, n_compared = 0, i, k;
    reg  [2:0]   conds [0:4];
    host_model i_host_model (.core_clk_i(core_clk_i), .we_o(we), .ch_o(ch), .val_o(val), .arm_o(arm));
    ela_trigger i_ela_trigger (.core_clk_i(core_clk_i), .rst_i(rst_i), .probe_i(probe_i), .cond_we_i(we),
        .cond_ch_i(ch), .cond_val_i(val), .arm_i(arm), .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o),
        .armed_o(armed_o), .triggered_o(triggered_o), .done_o(done_o), .trig_pos_o(trig_pos_o));
    initial begin
        core_clk_i = 1'b0;
        forever #4 core_clk_i = ~core_clk_i;
    end
    always @(posedge core_clk_i) probe_i <= {lead, probe_i[126:0] + 127'h1};
    task check(input string name, input [127:0] seen, input [127:0] exp);
        begin
            n_compared++;
            if (seen !== exp) begin
                mismatches++;
                $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
            end
        end
    endtask
    task end_sim;
        begin
            $display("compared %0d mismatches %0d", n_compared, mismatches);
            if (mismatches == 0 && n_compared > 0) $display("RESULT: PASS");
            else $display("RESULT: FAIL");
            $finish;
        end
    endtask
    task wait_for(input integer sel, input integer lim);
        begin
            hit = 1'b0;
            for (i = 0; i < lim && !hit; i++) begin
                @(posedge core_clk_i); #1 hit = ((sel ? done_o : triggered_o) === 1'b1);
            end
            if (!hit) begin
                mismatches++;
                end_sim;
            end
        end
    endtask
    task do_reset;
        begin
            @(posedge core_clk_i); rst_i <= 1'b1;
            repeat (10) @(posedge core_clk_i);
            rst_i <= 1'b0;
            @(posedge core_clk_i); #1 check("idle", {done_o, armed_o, triggered_o}, 3'h0);
        end
    endtask
    task read_win(input [6:0] a);
        begin
            @(posedge core_clk_i); rd_addr_i <= a;
            repeat (3) @(posedge core_clk_i);
            #1;
        end
    endtask
    task s_default;
        begin
            do_reset;
            i_host_model.arm;
            wait_for(0, 300);
            wait_for(1, 30);
            check("trig_pos", trig_pos_o, 7'h71);
            for (k = 0; k < 128; k++) begin
                read_win(k[6:0]);
                if (k > 0) check("window", rd_data_o[126:0], prev[126:0] + 127'h1);
                prev = rd_data_o;
            end
        end
    endtask
    task s_conds;
        begin
            conds[0] = `COND_LOW; conds[1] = `COND_HIGH; conds[2] = `COND_RISE;
            conds[3] = `COND_FALL; conds[4] = `COND_EITHER;
            for (k = 0; k < 5; k++) begin
                do_reset;
                lead <= (k == 0 || k == 3);
                i_host_model.set_cond(8'h7F, conds[k]);
                i_host_model.set_cond(8'h00, 3'h6);
                i_host_model.arm;
                hit = 1'b0;
                repeat (200) begin
                    @(posedge core_clk_i);
                    #1 hit = hit | (triggered_o === 1'b1);
                end
                check("early", hit, 1'b0);
                lead <= !(k == 0 || k == 3);
                wait_for(0, 8);
                wait_for(1, 30);
                read_win(7'h70);
                check("pre_sample", rd_data_o[127], (k == 0 || k == 3));
                read_win(7'h71);
                check("trig_sample", rd_data_o[127], !(k == 0 || k == 3));
            end
        end
    endtask
    initial begin
        rst_i = 1'b1; lead = 1'b0; probe_i = 128'h0; rd_addr_i = 7'h00; prev = 128'h0;
        s_default;
        s_conds;
        end_sim;
    end
endmodule // ela_trigger_tb
